// ### sspt_consts.svh
// Constants for the sensor serial register port
// Operation
// - Two-wire write address 111011X0, X from pin
// - Two-wire write takes address/data pairs, no increment
// - Two-wire read increments address until host NACK
// - Modes 00/11 picked from clock at select
// - Three-wire uses data pin, output pin floats
// - Sample on rising edge, drive on falling
// - Select low frames transaction, clock stable then
// - Seven address bits, top bit is direction
// - Control bytes 0x77 and 0xF7 reach 0xF7
// - Write pairs repeat until select rises
// - Read shifts out bytes, address advances
// - Select active low, undriven reads inactive
// - Three-wire enable is bit 0 of 0xF5
// - Select low once disables two-wire until reset
// - Device never stretches the two-wire clock
`ifndef SSPT_CONSTS_SVH
`define SSPT_CONSTS_SVH

`define SSPT_DEV_ADDR_HI 6'h3b
`define SSPT_CFG_ADDR    8'hf5
`define SSPT_TW_BIT      0
`define SSPT_RW_BIT      7
`define SSPT_ADDR_MSB    1'b1
`define SSPT_TW_RESET    1'b0
`define SSPT_MODE_RESET  1'b0
`define SSPT_PTR_RESET   8'h00
`define SSPT_SYNC_RESET  5'h1c
`define SSPT_BYTE_LAST   3'h7
`define SSPT_I2C_BITS    4'h8

`endif

// ### sspt_host_model.sv
// Host serial master model: two-wire bus and serial peripheral link
`timescale 1ns/1ps
`default_nettype none

module sspt_host_model
(
  input  wire logic clk_in,
  input  wire logic sdi_in,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_in,
  output logic      sck_out,
  output logic      csb_out,
  output logic      sdi_out,
  output logic      rel_out
);
  // Select idles high, two-wire lines released
  initial
  begin
    sck_out = 1'b1;
    csb_out = 1'b1;
    sdi_out = 1'b1;
    rel_out = 1'b0;
  end

  // ==========================================
  // Two-wire master
  // Quarter bit of 5 ref cycles; host owns every clock low
  task automatic qw();
    repeat (5) @(posedge clk_in);
  endtask

  // Start and repeated start: data raised first so no stop is seen
  task automatic i2c_start();
    @(posedge clk_in);
    rel_out <= 1'b0;
    sdi_out <= 1'b1;
    qw();
    sck_out <= 1'b1;
    qw();
    sdi_out <= 1'b0;
    qw();
    sck_out <= 1'b0;
    qw();
  endtask

  task automatic i2c_stop();
    sdi_out <= 1'b0;
    qw();
    sck_out <= 1'b1;
    qw();
    sdi_out <= 1'b1;
    qw();
  endtask

  // Eight bits then the acknowledge slot; r is the line in that slot
  task automatic i2c_byte(input logic [7:0] tx, input logic a,
                          output logic [7:0] rx, output logic r);
    logic [8:0] w;
    logic [8:0] v;
    w = {tx, a};
    for (int i = 8; i >= 0; i--)
    begin
      sdi_out <= w[i];
      qw();
      sck_out <= 1'b1;
      qw();
      v[i] = sdi_in;
      qw();
      sck_out <= 1'b0;
      qw();
    end
    rx = v[8:1];
    r = v[0];
  endtask

  // ==========================================
  // Serial peripheral master
  // Select moves only while the clock rests
  task automatic spi_sel(input logic lo, input logic idle);
    sck_out = idle;
    #7.3;
    csb_out = !lo;
    #21;
  endtask

  // Host shifts on the fall and samples on the rise; released line toggles
  task automatic spi_byte(input logic [7:0] tx, input logic rd, input logic tw,
                          input logic m11, output logic [7:0] rx, output logic oe);
    oe = 1'b0;
    rel_out = rd & tw;
    for (int i = 7; i >= 0; i--)
    begin
      sck_out = 1'b0;
      sdi_out = rel_out ? !sdi_out : tx[i];
      #3;
      sck_out = 1'b1;
      rx[i] = tw ? sdi_in : sdo_in;
      oe = oe | sdo_oe_in;
      #3;
    end
    sck_out = m11;
    #200;
  endtask
endmodule
`default_nettype wire

// ### sspt_pkg.sv
// Types shared by the sensor serial register port
`default_nettype none
package sspt_pkg;
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_HACK} sspt_i2c_state_t;
  typedef enum logic [1:0] {S_CTRL, S_WDATA, S_READ} sspt_spi_state_t;
endpackage
`default_nettype wire

// ### sspt_port.sv
// Serial register port: two-wire and serial peripheral slave access
`timescale 1ns/1ps
`default_nettype none
`include "sspt_consts.svh"

module sspt_port
(
  input  wire logic       REF_CLK_IN,
  input  wire logic       RESETN_IN,
  input  wire logic       SCK_IN,
  input  wire logic       CSB_IN,
  input  wire logic       SDI_IN,
  output logic            SDI_OUT,
  output logic            SDI_OE_OUT,
  input  wire logic       SDO_IN,
  output logic            SDO_OUT,
  output logic            SDO_OE_OUT,
  output logic            REG_WE_OUT,
  output logic [7:0]      REG_WADDR_OUT,
  output logic [7:0]      REG_WDATA_OUT,
  output logic [7:0]      REG_RADDR_OUT,
  input  wire logic [7:0] REG_RDATA_IN,
  output logic [7:0]      LINK_RADDR_OUT,
  input  wire logic [7:0] LINK_RDATA_IN,
  output logic            SPI_MODE11_OUT,
  output logic            I2C_OFF_OUT,
  output logic            THREE_WIRE_OUT
);

  // ==========================================================
  // Declarations
  logic                      rst_m_reg;
  logic                      rst_n;
  logic [4:0]                sync_m_reg;
  logic [4:0]                sync_s_reg;
  logic [4:0]                sync_d_reg;
  logic                      csb_s;
  logic                      csb_d;
  logic                      scl_s;
  logic                      scl_d;
  logic                      sda_s;
  logic                      sda_d;
  logic                      sdo_s;
  logic                      tgl_s;
  logic                      tgl_d;
  logic                      i2c_off_reg;
  logic                      mode11_reg;
  logic                      tw_reg;
  logic                      i2c_en;
  logic                      scl_rise;
  logic                      scl_fall;
  logic                      start_det;
  logic                      stop_det;
  sspt_pkg::sspt_i2c_state_t i_state_reg;
  logic [3:0]                i_cnt_reg;
  logic [7:0]                i_shift_reg;
  logic                      i_first_reg;
  logic                      i_rw_reg;
  logic                      i_phase_reg;
  logic [7:0]                ptr_reg;
  logic                      sda_drv_reg;
  logic                      i_wr_reg;
  logic [7:0]                i_wdata_reg;
  logic                      spi_clr;
  sspt_pkg::sspt_spi_state_t s_state_reg;
  logic [2:0]                s_cnt_reg;
  logic [7:0]                s_shift_reg;
  logic [7:0]                s_addr_reg;
  logic [7:0]                s_byte;
  logic                      s_wr_done;
  logic                      wr_tgl_reg;
  logic [7:0]                wr_addr_reg;
  logic [7:0]                wr_data_reg;
  logic                      tw_m_reg;
  logic                      tw_s_reg;
  logic [7:0]                s_out_reg;
  logic                      s_drv_reg;

  // ==========================================================
  // Reset release and pin synchronisers
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rst_m_reg <= 1'b0;
      rst_n     <= 1'b0;
    end
    else
    begin
      rst_m_reg <= 1'b1;
      rst_n     <= rst_m_reg;
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_m_reg <= `SSPT_SYNC_RESET;
      sync_s_reg <= `SSPT_SYNC_RESET;
      sync_d_reg <= `SSPT_SYNC_RESET;
    end
    else
    begin
      sync_m_reg <= {CSB_IN, SCK_IN, SDI_IN, SDO_IN, wr_tgl_reg};
      sync_s_reg <= sync_m_reg;
      sync_d_reg <= sync_s_reg;
    end
  end

  assign csb_s     = sync_s_reg[4];
  assign csb_d     = sync_d_reg[4];
  assign scl_s     = sync_s_reg[3];
  assign scl_d     = sync_d_reg[3];
  assign sda_s     = sync_s_reg[2];
  assign sda_d     = sync_d_reg[2];
  assign sdo_s     = sync_s_reg[1];
  assign tgl_s     = sync_s_reg[0];
  assign tgl_d     = sync_d_reg[0];
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;
  assign i2c_en    = !i2c_off_reg && csb_s;

  // ==========================================================
  // Interface selection and mode pick
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i2c_off_reg <= 1'b0;
      mode11_reg  <= `SSPT_MODE_RESET;
    end
    else
    begin
      if (!csb_s)
        i2c_off_reg <= 1'b1;
      if (csb_d && !csb_s)
        mode11_reg <= scl_s;
    end
  end

  // ==========================================================
  // Two-wire slave engine
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      i_state_reg <= sspt_pkg::I_IDLE;
      i_cnt_reg   <= 4'h0;
      i_shift_reg <= 8'h00;
      i_first_reg <= 1'b0;
      i_rw_reg    <= 1'b0;
      i_phase_reg <= 1'b0;
      ptr_reg     <= `SSPT_PTR_RESET;
      sda_drv_reg <= 1'b0;
      i_wr_reg    <= 1'b0;
      i_wdata_reg <= 8'h00;
    end
    else
    begin
      i_wr_reg <= 1'b0;
      if (!i2c_en || stop_det)
      begin
        i_state_reg <= sspt_pkg::I_IDLE;
        sda_drv_reg <= 1'b0;
      end
      else if (start_det)
      begin
        i_state_reg <= sspt_pkg::I_RX;
        i_cnt_reg   <= 4'h0;
        i_first_reg <= 1'b1;
        sda_drv_reg <= 1'b0;
      end
      else
      begin
        case (i_state_reg)
          sspt_pkg::I_RX:
          begin
            if (scl_rise)
            begin
              i_shift_reg <= {i_shift_reg[6:0], sda_s};
              i_cnt_reg   <= i_cnt_reg + 4'h1;
            end
            else if (scl_fall && i_cnt_reg == `SSPT_I2C_BITS)
            begin
              i_cnt_reg <= 4'h0;
              if (i_first_reg)
              begin
                i_first_reg <= 1'b0;
                i_phase_reg <= 1'b0;
                i_rw_reg    <= i_shift_reg[0];
                if (i_shift_reg[7:1] == {`SSPT_DEV_ADDR_HI, sdo_s})
                begin
                  i_state_reg <= sspt_pkg::I_ACK;
                  sda_drv_reg <= 1'b1;
                end
                else
                  i_state_reg <= sspt_pkg::I_IDLE;
              end
              else
              begin
                // Pairs: register address, then data; no increment
                if (!i_phase_reg)
                  ptr_reg <= i_shift_reg;
                else
                begin
                  i_wr_reg    <= 1'b1;
                  i_wdata_reg <= i_shift_reg;
                end
                i_phase_reg <= !i_phase_reg;
                i_state_reg <= sspt_pkg::I_ACK;
                sda_drv_reg <= 1'b1;
              end
            end
          end
          sspt_pkg::I_ACK:
          begin
            if (scl_fall)
            begin
              if (i_rw_reg)
              begin
                i_state_reg <= sspt_pkg::I_TX;
                i_shift_reg <= REG_RDATA_IN;
                sda_drv_reg <= !REG_RDATA_IN[7];
                ptr_reg     <= ptr_reg + 8'h01;
                i_cnt_reg   <= 4'h0;
              end
              else
              begin
                i_state_reg <= sspt_pkg::I_RX;
                sda_drv_reg <= 1'b0;
              end
            end
          end
          sspt_pkg::I_TX:
          begin
            if (scl_fall)
            begin
              if (i_cnt_reg[2:0] == `SSPT_BYTE_LAST)
              begin
                sda_drv_reg <= 1'b0;
                i_state_reg <= sspt_pkg::I_HACK;
              end
              else
              begin
                i_shift_reg <= {i_shift_reg[6:0], 1'b0};
                sda_drv_reg <= !i_shift_reg[6];
                i_cnt_reg   <= i_cnt_reg + 4'h1;
              end
            end
          end
          sspt_pkg::I_HACK:
          begin
            if (scl_rise && sda_s)
              i_state_reg <= sspt_pkg::I_IDLE;
            else if (scl_fall)
            begin
              i_state_reg <= sspt_pkg::I_TX;
              i_shift_reg <= REG_RDATA_IN;
              sda_drv_reg <= !REG_RDATA_IN[7];
              ptr_reg     <= ptr_reg + 8'h01;
              i_cnt_reg   <= 4'h0;
            end
          end
          default:
            i_state_reg <= sspt_pkg::I_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // Register write port and configuration copy
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      REG_WE_OUT    <= 1'b0;
      REG_WADDR_OUT <= 8'h00;
      REG_WDATA_OUT <= 8'h00;
    end
    else
    begin
      REG_WE_OUT <= 1'b0;
      if (tgl_s != tgl_d)
      begin
        REG_WE_OUT    <= 1'b1;
        REG_WADDR_OUT <= wr_addr_reg;
        REG_WDATA_OUT <= wr_data_reg;
      end
      else if (i_wr_reg)
      begin
        REG_WE_OUT    <= 1'b1;
        REG_WADDR_OUT <= ptr_reg;
        REG_WDATA_OUT <= i_wdata_reg;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      tw_reg <= `SSPT_TW_RESET;
    else if (REG_WE_OUT && REG_WADDR_OUT == `SSPT_CFG_ADDR)
      tw_reg <= REG_WDATA_OUT[`SSPT_TW_BIT];
  end

  // ==========================================================
  // Serial peripheral link, clocked by the host clock
  // Select high (pulled up when undriven) holds the link idle
  assign spi_clr   = CSB_IN || !rst_n;
  assign s_byte    = {s_shift_reg[6:0], SDI_IN};
  assign s_wr_done = (s_state_reg == sspt_pkg::S_WDATA) && (s_cnt_reg == `SSPT_BYTE_LAST);

  always_ff @(posedge SCK_IN or posedge spi_clr)
  begin
    if (spi_clr)
    begin
      s_state_reg <= sspt_pkg::S_CTRL;
      s_cnt_reg   <= 3'h0;
      s_shift_reg <= 8'h00;
      s_addr_reg  <= 8'h00;
    end
    else
    begin
      s_cnt_reg   <= s_cnt_reg + 3'h1;
      s_shift_reg <= s_byte;
      if (s_cnt_reg == `SSPT_BYTE_LAST)
      begin
        case (s_state_reg)
          sspt_pkg::S_CTRL:
          begin
            s_addr_reg <= {`SSPT_ADDR_MSB, s_byte[6:0]};
            if (s_byte[`SSPT_RW_BIT])
              s_state_reg <= sspt_pkg::S_READ;
            else
              s_state_reg <= sspt_pkg::S_WDATA;
          end
          sspt_pkg::S_WDATA:
            s_state_reg <= sspt_pkg::S_CTRL;
          sspt_pkg::S_READ:
            s_addr_reg <= s_addr_reg + 8'h01;
          default:
            s_state_reg <= sspt_pkg::S_CTRL;
        endcase
      end
    end
  end

  // Held across frames; read in the reference domain by toggle
  always_ff @(posedge SCK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_tgl_reg  <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end
    else if (s_wr_done && !CSB_IN)
    begin
      wr_tgl_reg  <= !wr_tgl_reg;
      wr_addr_reg <= s_addr_reg;
      wr_data_reg <= s_byte;
    end
  end

  always_ff @(posedge SCK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tw_m_reg <= `SSPT_TW_RESET;
      tw_s_reg <= `SSPT_TW_RESET;
    end
    else
    begin
      tw_m_reg <= tw_reg;
      tw_s_reg <= tw_m_reg;
    end
  end

  // Read data launched on the falling edge
  always_ff @(negedge SCK_IN or posedge spi_clr)
  begin
    if (spi_clr)
    begin
      s_out_reg <= 8'h00;
      s_drv_reg <= 1'b0;
    end
    else if (s_state_reg == sspt_pkg::S_READ)
    begin
      if (s_cnt_reg == 3'h0)
      begin
        s_out_reg <= LINK_RDATA_IN;
        s_drv_reg <= 1'b1;
      end
      else
        s_out_reg <= {s_out_reg[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Pins and status
  assign SDO_OUT        = s_out_reg[7];
  assign SDO_OE_OUT     = s_drv_reg && !tw_s_reg;
  assign SDI_OUT        = s_drv_reg && tw_s_reg && s_out_reg[7];
  assign SDI_OE_OUT     = sda_drv_reg || (s_drv_reg && tw_s_reg);
  assign REG_RADDR_OUT  = ptr_reg;
  assign LINK_RADDR_OUT = s_addr_reg;
  assign SPI_MODE11_OUT = mode11_reg;
  assign I2C_OFF_OUT    = i2c_off_reg;
  assign THREE_WIRE_OUT = tw_reg;

  // ==========================================================
  // Checks
  sequence seq_cs_fall;
    csb_d && !csb_s;
  endsequence

  sequence seq_cfg_write;
    REG_WE_OUT && REG_WADDR_OUT == `SSPT_CFG_ADDR;
  endsequence

  chk_lock_sticky: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    seq_cs_fall |=> i2c_off_reg ##1 i2c_off_reg)
    else $error("two-wire not locked after select low");

  chk_lock_quiet: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    i2c_off_reg |-> !sda_drv_reg && i_state_reg == sspt_pkg::I_IDLE)
    else $error("two-wire active while locked");

  chk_mode_pick: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    seq_cs_fall |=> mode11_reg == $past(scl_s))
    else $error("clock mode not taken from clock level");

  chk_cfg_bit: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    seq_cfg_write |=> tw_reg == $past(REG_WDATA_OUT[0]))
    else $error("three-wire enable not updated");

  chk_i2c_addr_ack: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (i_state_reg == sspt_pkg::I_RX && i_first_reg && scl_fall && !start_det && !stop_det
     && i2c_en && i_cnt_reg == 4'h8 && i_shift_reg[7:1] != {6'h3b, sdo_s})
    |=> !sda_drv_reg)
    else $error("acknowledged a foreign address");

  chk_i2c_rd_incr: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    (i_state_reg == sspt_pkg::I_TX && $past(i_state_reg) != sspt_pkg::I_TX)
    |-> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("read pointer did not advance");

  chk_wr_pulse: assert property (@(posedge REF_CLK_IN) disable iff (!rst_n)
    i_wr_reg |=> REG_WE_OUT ##1 !REG_WE_OUT)
    else $error("write strobe not one cycle");

  chk_spi_addr: assert property (@(posedge SCK_IN) disable iff (spi_clr)
    (s_state_reg == sspt_pkg::S_CTRL && s_cnt_reg == 3'h7)
    |=> s_addr_reg == {1'b1, $past(s_byte[6:0])})
    else $error("control byte decoded to wrong register");

  chk_spi_rd_adv: assert property (@(posedge SCK_IN) disable iff (spi_clr)
    (s_state_reg == sspt_pkg::S_READ && s_cnt_reg == 3'h7)
    |=> s_addr_reg == $past(s_addr_reg) + 8'h01)
    else $error("serial read address did not advance");

  chk_three_wire_hiz: assert property (@(negedge SCK_IN) disable iff (spi_clr)
    tw_s_reg |-> !SDO_OE_OUT)
    else $error("output pin driven in three-wire mode");

endmodule
`default_nettype wire

// ### test_sensor_serial_register_port.sv
// Bench for the sensor serial register port
`timescale 1ns/1ps
`default_nettype none

module test_sensor_serial_register_port;
  logic       clk, rstn, sck, csb, h_sdi, h_rel, strap, sdi_line, sdi_o, sdi_oe;
  logic       sdo_o, sdo_oe, sdo_line, we, mode11, i2c_off, three_wire, m11, sel_tw;
  logic [7:0] waddr, wdata, raddr, laddr;
  logic [7:0] regs [256];
  int         mismatches = 0;
  int         total_checks = 0;
  int         writes = 0;

  // Data pin: open drain in two-wire, device-driven in three-wire reads
  assign sdi_line = sdi_oe ? (sdi_o & (h_rel | h_sdi)) : h_sdi;
  // Output pin: floating shows the inverse of the device's bit
  assign sdo_line = sdo_oe ? sdo_o : !sdo_o;

  sspt_port dut
  (
    .REF_CLK_IN(clk), .RESETN_IN(rstn), .SCK_IN(sck), .CSB_IN(csb), .SDI_IN(sdi_line),
    .SDI_OUT(sdi_o), .SDI_OE_OUT(sdi_oe), .SDO_IN(strap), .SDO_OUT(sdo_o),
    .SDO_OE_OUT(sdo_oe), .REG_WE_OUT(we), .REG_WADDR_OUT(waddr), .REG_WDATA_OUT(wdata),
    .REG_RADDR_OUT(raddr), .REG_RDATA_IN(regs[raddr]), .LINK_RADDR_OUT(laddr),
    .LINK_RDATA_IN(regs[laddr]), .SPI_MODE11_OUT(mode11), .I2C_OFF_OUT(i2c_off),
    .THREE_WIRE_OUT(three_wire)
  );

  sspt_host_model host
  (
    .clk_in(clk), .sdi_in(sdi_line), .sdo_in(sdo_line), .sdo_oe_in(sdo_oe),
    .sck_out(sck), .csb_out(csb), .sdi_out(h_sdi), .rel_out(h_rel)
  );

  // ==========================================
  // Register file behind the port
  always @(posedge clk)
  begin
    if (we === 1'b1)
    begin
      regs[waddr] <= wdata;
      writes <= writes + 1;
    end
  end

  // ==========================================
  // Helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ib(input logic [7:0] tx, input logic a, input logic [7:0] erx, input logic er);
    logic [7:0] rx;
    logic       r;
    host.i2c_byte(tx, a, rx, r);
    check(rx, erx);
    check({7'h00, r}, {7'h00, er});
  endtask

  task automatic sb(input logic [7:0] tx, input logic rd, input logic [7:0] erx, input logic eoe);
    logic [7:0] rx;
    logic       oe;
    host.spi_byte(tx, rd, sel_tw, m11, rx, oe);
    if (rd)
    begin
      check(rx, erx);
      check({7'h00, oe}, {7'h00, eoe});
    end
  endtask

  task automatic reset_dut();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic test_two_wire();
    host.i2c_start();
    ib(8'hec, 1'b1, 8'hec, 1'b0);
    ib(8'h10, 1'b1, 8'h10, 1'b0);
    ib(8'ha5, 1'b1, 8'ha5, 1'b0);
    ib(8'h20, 1'b1, 8'h20, 1'b0);
    ib(8'h3c, 1'b1, 8'h3c, 1'b0);
    host.i2c_stop();
    check(regs[8'h10], 8'ha5);
    check(regs[8'h11], 8'h4d);
    check(regs[8'h20], 8'h3c);
    strap <= 1'b1;
    host.i2c_start();
    ib(8'hec, 1'b1, 8'hec, 1'b1);
    host.i2c_stop();
    host.i2c_start();
    ib(8'hee, 1'b1, 8'hee, 1'b0);
    ib(8'h1f, 1'b1, 8'h1f, 1'b0);
    host.i2c_start();
    ib(8'hef, 1'b1, 8'hef, 1'b0);
    ib(8'hff, 1'b0, 8'h43, 1'b0);
    ib(8'hff, 1'b0, 8'h3c, 1'b0);
    ib(8'hff, 1'b1, 8'h7d, 1'b1);
    host.i2c_stop();
    check(writes[7:0], 8'h02);
    check({7'h00, i2c_off}, 8'h00);
    $display("two-wire test done");
  endtask

  task automatic test_spi_read4();
    m11 = 1'b1;
    host.spi_sel(1'b1, 1'b1);
    sb(8'hf7, 1'b0, 8'h00, 1'b0);
    sb(8'h00, 1'b1, 8'hab, 1'b1);
    sb(8'h00, 1'b1, 8'ha4, 1'b1);
    check({7'h00, mode11}, 8'h01);
    host.spi_sel(1'b0, 1'b1);
    check({7'h00, sdo_oe}, 8'h00);
    check({7'h00, i2c_off}, 8'h01);
    strap <= 1'b0;
    host.i2c_start();
    ib(8'hec, 1'b1, 8'hec, 1'b1);
    host.i2c_stop();
    $display("four-wire read test done");
  endtask

  task automatic test_spi_write();
    m11 = 1'b0;
    host.spi_sel(1'b1, 1'b0);
    sb(8'h77, 1'b0, 8'h00, 1'b0);
    sb(8'h5a, 1'b0, 8'h00, 1'b0);
    sb(8'h75, 1'b0, 8'h00, 1'b0);
    sb(8'h01, 1'b0, 8'h00, 1'b0);
    check({7'h00, mode11}, 8'h00);
    host.spi_sel(1'b0, 1'b0);
    check(regs[8'hf7], 8'h5a);
    check(regs[8'hf5], 8'h01);
    check({7'h00, three_wire}, 8'h01);
    check(writes[7:0], 8'h04);
    $display("write test done");
  endtask

  task automatic test_spi_read3();
    sel_tw = 1'b1;
    host.spi_sel(1'b1, 1'b0);
    sb(8'hf6, 1'b0, 8'h00, 1'b0);
    sb(8'h00, 1'b1, 8'haa, 1'b0);
    sb(8'h00, 1'b1, 8'h5a, 1'b0);
    host.spi_sel(1'b0, 1'b0);
    $display("three-wire read test done");
  endtask

  task automatic test_reset();
    reset_dut();
    check({6'h00, i2c_off, three_wire}, 8'h00);
    host.i2c_start();
    ib(8'hec, 1'b1, 8'hec, 1'b0);
    host.i2c_stop();
    $display("reset test done");
  endtask

  // ==========================================
  // Clock, sequence and watchdog
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    rstn = 1'b0;
    strap = 1'b0;
    m11 = 1'b0;
    sel_tw = 1'b0;
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i) ^ 8'h5c;
    reset_dut();
    test_two_wire();
    test_spi_read4();
    test_spi_write();
    test_spi_read3();
    test_reset();
    complete_run();
  end

  initial
  begin
    repeat (50000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
